// ===== rtl/sacir_regs.sv
`timescale 1ns/1ps
`include "sacir_cfg.svh"
module sacir_regs #(
    parameter int unsigned PAUSE_LIMIT = `SACIR_PAUSE_CYCLES
) (
    input  wire logic                   clk,            // Core clock, 10 MHz
    input  wire logic                   rst,            // Synchronous reset
    input  wire logic                   ce,             // Clock enable
    input  sacir_pkg::sacir_req_t       req,            // Register access
    output logic [7:0]                  rd_data,        // Read data
    output logic                        rd_valid,       // Read data valid pulse
    input  sacir_pkg::sacir_link_t      link,           // Port link states
    input  wire logic                   global_order,   // Global priority-order bit
    input  wire logic                   pause_off_act,  // Forced pause off active
    output logic                        pause_inval_req,// Invalidate flow control
    output sacir_pkg::sacir_sched_t     egress_queue_mode, // Queue service order
    output logic                        core_regulator_dis, // Core regulator off
    output sacir_pkg::sacir_vlan_ins_t  port_default_vlan_id_ins, // Insert enables
    output logic                        irq_out_low     // Interrupt, active low
);

    // ----------------------------------------
    // Decode helper
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    logic [7:0] sched_reg;
    logic [7:0] irq_en_reg;
    logic [7:0] irq_stat_reg;
    logic [7:0] irq_stat_next;
    logic [7:0] pause_reg;
    logic [7:0] regul_reg;
    logic [7:0] vlan_reg;
    logic [2:0] link_prev_reg;
    logic       link_seen_reg;
    logic [2:0] link_chg;
    logic [7:0] rd_next;
    logic       wr_sched;
    logic       wr_en;
    logic       wr_stat;
    logic       wr_pause;
    logic       wr_regul;
    logic       wr_vlan;

    assign wr_sched = req.wr && hit(req.addr, `SACIR_OFF_SCHED);
    assign wr_en    = req.wr && hit(req.addr, `SACIR_OFF_IRQ_EN);
    assign wr_stat  = req.wr && hit(req.addr, `SACIR_OFF_IRQ_STAT);
    assign wr_pause = req.wr && hit(req.addr, `SACIR_OFF_PAUSE);
    assign wr_regul = req.wr && hit(req.addr, `SACIR_OFF_REGUL);
    assign wr_vlan  = req.wr && hit(req.addr, `SACIR_OFF_VLAN_INS);

    // ----------------------------------------
    // Queue scheduling select
    // ----------------------------------------
    // Only the select bit is writable; the low bits keep their default
    always_ff @(posedge clk) begin
        if (rst) begin
            sched_reg <= `SACIR_RST_SCHED;
        end else if (ce && wr_sched) begin
            sched_reg[`SACIR_SCHED_SEL_BIT] <= req.wdata[`SACIR_SCHED_SEL_BIT];
        end
    end

    // Strict only when both the port select and the global order bit are clear
    always_comb begin
        if (!sched_reg[`SACIR_SCHED_SEL_BIT] && !global_order) begin
            egress_queue_mode = sacir_pkg::SACIR_STRICT;
        end else begin
            egress_queue_mode = sacir_pkg::SACIR_WEIGHTED;
        end
    end

    // ----------------------------------------
    // Interrupt enable
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_en_reg <= `SACIR_RST_IRQ_EN;
        end else if (ce && wr_en) begin
            irq_en_reg <= req.wdata;
        end
    end

    // ----------------------------------------
    // Link change detection
    // ----------------------------------------
    // First sample after reset only primes the history, so no false flag
    always_ff @(posedge clk) begin
        if (rst) begin
            link_prev_reg <= 3'h0;
            link_seen_reg <= 1'b0;
        end else if (ce) begin
            link_prev_reg <= link;
            link_seen_reg <= 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chg
            assign link_chg[gi] = link_seen_reg && (link[gi] != link_prev_reg[gi]);
        end
    endgenerate

    // ----------------------------------------
    // Link change status
    // ----------------------------------------
    // New events win over a clear in the same cycle, so none is lost
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (wr_stat) begin
            irq_stat_next = irq_stat_reg & ~req.wdata;
        end
        if (link_chg[0] || link_chg[1]) begin
            irq_stat_next[`SACIR_STAT_P12_BIT] = 1'b1;
        end
        if (link_chg[2]) begin
            irq_stat_next[`SACIR_STAT_P3_BIT] = 1'b1;
        end
        if (link_chg[1]) begin
            irq_stat_next[`SACIR_STAT_P2_BIT] = 1'b1;
        end
        if (link_chg[0]) begin
            irq_stat_next[`SACIR_STAT_P1_BIT] = 1'b1;
        end
        irq_stat_next = irq_stat_next & `SACIR_STAT_MASK;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_reg <= `SACIR_RST_IRQ_STAT;
        end else if (ce) begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    // Built from flops only, so the pin cannot glitch on bus activity
    assign irq_out_low = ~|(irq_stat_reg & irq_en_reg);

    // ----------------------------------------
    // Pause limit, regulator, VLAN insertion
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            pause_reg <= `SACIR_RST_PAUSE;
        end else if (ce && wr_pause) begin
            pause_reg <= req.wdata;
        end
    end

    // Reserved bits of the regulator register stay at zero
    always_ff @(posedge clk) begin
        if (rst) begin
            regul_reg <= `SACIR_RST_REGUL;
        end else if (ce && wr_regul) begin
            regul_reg[`SACIR_REGUL_DIS_BIT] <= req.wdata[`SACIR_REGUL_DIS_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            vlan_reg <= `SACIR_RST_VLAN_INS;
        end else if (ce && wr_vlan) begin
            vlan_reg <= req.wdata & `SACIR_VLAN_MASK;
        end
    end

    assign core_regulator_dis       = regul_reg[`SACIR_REGUL_DIS_BIT];
    assign port_default_vlan_id_ins = sacir_pkg::sacir_vlan_ins_t'(vlan_reg[5:0]);

    sacir_pause_timer #(
        .LIMIT (PAUSE_LIMIT)
    ) u_pause_timer (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .enable  (pause_reg[`SACIR_PAUSE_EN_BIT]),
        .active  (pause_off_act),
        .expired (pause_inval_req)
    );

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Unmapped offsets read zero; 0xc0 is a constant, so writes there vanish
    always_comb begin
        rd_next = 8'h00;
        if (hit(req.addr, `SACIR_OFF_SCHED)) begin
            rd_next = sched_reg;
        end else if (hit(req.addr, `SACIR_OFF_IRQ_EN)) begin
            rd_next = irq_en_reg;
        end else if (hit(req.addr, `SACIR_OFF_IRQ_STAT)) begin
            rd_next = irq_stat_reg;
        end else if (hit(req.addr, `SACIR_OFF_PAUSE)) begin
            rd_next = pause_reg;
        end else if (hit(req.addr, `SACIR_OFF_RSVD_C0)) begin
            rd_next = `SACIR_RST_RSVD_C0;
        end else if (hit(req.addr, `SACIR_OFF_REGUL)) begin
            rd_next = regul_reg;
        end else if (hit(req.addr, `SACIR_OFF_VLAN_INS)) begin
            rd_next = vlan_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else if (ce) begin
            rd_valid <= req.rd;
            if (req.rd) begin
                rd_data <= rd_next;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_strict_order: assert property (
        (!sched_reg[7] && !global_order) |-> egress_queue_mode == sacir_pkg::SACIR_STRICT)
        else $error("strict order not selected");

    a_sel_after_reset: assert property (
        $fell(rst) |-> sched_reg[7] && egress_queue_mode == sacir_pkg::SACIR_WEIGHTED)
        else $error("select bit not one after reset");

    a_w1c_clear: assert property (
        (ce && wr_stat && req.wdata[0] && !link_chg[0]) |=> !irq_stat_reg[0])
        else $error("flag not cleared by write one");

    a_w0_keeps: assert property (
        (ce && wr_stat && !req.wdata[2] && irq_stat_reg[2]) |=> irq_stat_reg[2])
        else $error("flag lost on write zero");

    a_p12_change: assert property (
        (ce && (link_chg[0] || link_chg[1])) |=> irq_stat_reg[7])
        else $error("bit 7 not set on copper change");

    a_p3_change: assert property (
        (ce && link_seen_reg && link.p3_mii_up != link_prev_reg[2]) |=> irq_stat_reg[2])
        else $error("bit 2 not set on port 3 change");

    a_p2_change: assert property (
        (ce && link_chg[1]) |=> irq_stat_reg[1] && irq_stat_reg[7])
        else $error("bit 1 not set on port 2 change");

    a_p1_change: assert property (
        (ce && link_chg[0]) |=> irq_stat_reg[0] && irq_stat_reg[7])
        else $error("bit 0 not set on port 1 change");

    a_rsvd_zero: assert property (
        irq_stat_reg[6:3] == 4'h0)
        else $error("reserved status bits set");

    a_irq_pin: assert property (
        (|(irq_stat_reg & irq_en_reg)) == !irq_out_low)
        else $error("interrupt pin disagrees with flags");

    a_irq_masked: assert property (
        (ce && wr_en && req.wdata == 8'h00) |=> irq_out_low)
        else $error("interrupt with all enables off");

    a_c0_const: assert property (
        (req.rd && ce && hit(req.addr, `SACIR_OFF_RSVD_C0)) |=> rd_valid && rd_data == 8'h03)
        else $error("reserved register not 0x03");

    a_regul_bit: assert property (
        (ce && wr_regul) |=> core_regulator_dis == $past(req.wdata[6]) && regul_reg[5:0] == 6'h0)
        else $error("regulator bit wrong");

    a_pause_off: assert property (
        !pause_reg[0] |=> !pause_inval_req)
        else $error("flow control request with limit disabled");

    a_set_wins: assert property (
        (ce && wr_stat && req.wdata[0] && link_chg[0]) |=> irq_stat_reg[0])
        else $error("flag lost when event meets clear");

    a_weighted_sel: assert property (
        (sched_reg[7] || global_order) |-> egress_queue_mode == sacir_pkg::SACIR_WEIGHTED)
        else $error("weighted order not selected");

    a_en_reset: assert property (
        $fell(rst) |-> irq_en_reg == 8'h00 && irq_out_low)
        else $error("interrupt enables not zero after reset");

    a_vlan_map: assert property (
        (ce && wr_vlan) |=> port_default_vlan_id_ins == $past(req.wdata[5:0])
                            && vlan_reg[7:6] == 2'h0)
        else $error("insert enables do not follow register");

    a_pause_drop: assert property (
        (ce && !pause_off_act) |=> !pause_inval_req)
        else $error("flow control request outlives episode");

    c_vlan_ins: cover property (ce && wr_vlan && req.wdata[5:0] != 6'h00);
    c_irq_fire: cover property (irq_out_low ##1 !irq_out_low);
    c_clear_race: cover property (ce && wr_stat && req.wdata[0] && link_chg[0]);
    c_pause_req: cover property ($rose(pause_inval_req));
    c_weighted: cover property (egress_queue_mode == sacir_pkg::SACIR_WEIGHTED ##1
                                egress_queue_mode == sacir_pkg::SACIR_STRICT);
endmodule // sacir_regs

// ===== shared/sacir_cfg.svh
`ifndef SACIR_CFG_SVH
`define SACIR_CFG_SVH
// Functional notes
// - Select bit clear and global order bit clear: strict priority, highest first
// - Select bit set: 8:4:2:1 over four queues or 2:1 over two; resets to one
// - Eight enable bits gate matching status bits onto interrupt; reset zero
// - Status flags clear on writing one; writing zero leaves them unchanged
// - Status bit 7 sets when port 1 link, copper or MII, or port 2 copper link changes
// - Status bit 2 sets when port 3 link changes
// - Status bit 1 sets when port 2 copper link changes
// - Status bit 0 sets when port 1 link changes, copper or MII
// - Status bits 6 to 3 reserved, reset zero, kept at default
// - Limit enabled: wait 160 ms before asking to invalidate flow control
// - Regulator control bit 6 disables core regulator when set; resets zero
// - Bits 5 and 4: insert port 1 default VLAN ID at egress 2 and 3
// - Bits 3 and 2: insert port 2 default VLAN ID at egress 1 and 3
// - Bits 1 and 0: insert port 3 default VLAN ID at egress 1 and 2
// - Register 0xc0 reserved, reads 0x03, cannot be altered

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SACIR_OFF_SCHED     8'hba
`define SACIR_OFF_IRQ_EN    8'hbb
`define SACIR_OFF_IRQ_STAT  8'hbc
`define SACIR_OFF_PAUSE     8'hbd
`define SACIR_OFF_RSVD_C0   8'hc0
`define SACIR_OFF_REGUL     8'hc1
`define SACIR_OFF_VLAN_INS  8'hc2

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define SACIR_RST_SCHED     8'h81
`define SACIR_RST_IRQ_EN    8'h00
`define SACIR_RST_IRQ_STAT  8'h00
`define SACIR_RST_PAUSE     8'h00
`define SACIR_RST_RSVD_C0   8'h03
`define SACIR_RST_REGUL     8'h00
`define SACIR_RST_VLAN_INS  8'h00
`define SACIR_SCHED_SEL_BIT 7
`define SACIR_STAT_P12_BIT  7
`define SACIR_STAT_P3_BIT   2
`define SACIR_STAT_P2_BIT   1
`define SACIR_STAT_P1_BIT   0
`define SACIR_STAT_MASK     8'h87
`define SACIR_REGUL_DIS_BIT 6
`define SACIR_VLAN_MASK     8'h3f
`define SACIR_PAUSE_EN_BIT  0

// ----------------------------------------
// Timing
// ----------------------------------------
`define SACIR_CLK_KHZ        10000
`define SACIR_PAUSE_LIMIT_MS 160
`define SACIR_PAUSE_CYCLES   (`SACIR_PAUSE_LIMIT_MS * `SACIR_CLK_KHZ)
`endif

// ===== shared/sacir_pkg.sv
package sacir_pkg;
    // Link state of each monitored port
    typedef struct packed {
        logic p3_mii_up;  // Port 3 MII link
        logic p2_cu_up;   // Port 2 copper link
        logic p1_up;      // Port 1 link, copper or MII
    } sacir_link_t;

    // Register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sacir_req_t;

    // Egress-queue service order
    typedef enum logic {
        SACIR_STRICT,
        SACIR_WEIGHTED
    } sacir_sched_t;

    // Default VLAN ID insertion enables per source and egress port
    typedef struct packed {
        logic s1_e2;
        logic s1_e3;
        logic s2_e1;
        logic s2_e3;
        logic s3_e1;
        logic s3_e2;
    } sacir_vlan_ins_t;
endpackage

// ===== rtl/sacir_pause_timer.sv
`timescale 1ns/1ps
`include "sacir_cfg.svh"
module sacir_pause_timer #(
    parameter int unsigned LIMIT = `SACIR_PAUSE_CYCLES
) (
    input  wire logic clk,     // Core clock
    input  wire logic rst,     // Synchronous reset
    input  wire logic ce,      // Clock enable
    input  wire logic enable,  // Limit enabled
    input  wire logic active,  // Forced pause off in progress
    output logic      expired  // Ask to invalidate flow control
);
    localparam int CW = $clog2(LIMIT + 1);

    logic [CW-1:0] count_reg;

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // Restarts whenever the pause episode ends or the limit is disabled
    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
        end else if (ce) begin
            if (!enable || !active) begin
                count_reg <= '0;
            end else if (count_reg != CW'(LIMIT)) begin
                count_reg <= count_reg + CW'(1);
            end
        end
    end

    // Held until the episode ends; disabled limit never asks
    always_ff @(posedge clk) begin
        if (rst) begin
            expired <= 1'b0;
        end else if (ce) begin
            expired <= enable && active && (count_reg == CW'(LIMIT - 1)
                       || count_reg == CW'(LIMIT));
        end
    end
endmodule // sacir_pause_timer

// ===== dv/sacir_host.sv
`timescale 1ns/1ps
`include "sacir_cfg.svh"
module sacir_host (
    input  wire logic             clk,      // Core clock
    output sacir_pkg::sacir_req_t req,      // Register access
    input  wire logic [7:0]       rd_data,  // Read data
    input  wire logic             rd_valid  // Read data valid
);
    // ----------------------------------------
    // Host access tasks
    // ----------------------------------------
    // Idle bus at time zero
    initial begin
        req = '0;
    end

    // Requests move at the falling edge; the idle bus shows inverted values, not stale ones
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // The answer is registered at the taking edge, so it is read one half cycle later
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        v = rd_valid;
        d = rd_data;
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    endtask

    // Enables first, then stale flags cleared, before waiting on the pin
    task automatic arm_irq(input logic [7:0] en);
        write_reg(`SACIR_OFF_IRQ_EN, en);
        write_reg(`SACIR_OFF_IRQ_STAT, 8'hff);
    endtask
endmodule // sacir_host

// ===== dv/testbench.sv
`timescale 1ns/1ps
`include "sacir_cfg.svh"
module testbench;
    localparam int unsigned LIMIT = 20;
    logic                       clk;
    logic                       rst;
    logic                       ce;
    logic                       global_order;
    logic                       pause_off_act;
    sacir_pkg::sacir_req_t      req;
    sacir_pkg::sacir_link_t     link;
    logic [7:0]                 rd_data;
    logic                       rd_valid;
    logic                       pause_inval_req;
    logic                       core_regulator_dis;
    logic                       irq_out_low;
    sacir_pkg::sacir_sched_t    egress_queue_mode;
    sacir_pkg::sacir_vlan_ins_t port_default_vlan_id_ins;
    int                         miscompares;
    int                         tests_run;
    int                         cycles;
    int                         n;
    logic [7:0]                 rv;
    logic                       vv;
    logic [7:0] offs [8] = '{8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hc0, 8'hc1, 8'hc2, 8'hbe};
    logic [7:0] rsts [8] = '{8'h81, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};

    // ----------------------------------------
    // Clock, design and host
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    sacir_regs #(.PAUSE_LIMIT(LIMIT)) sacir_regs_inst (
        .clk(clk), .rst(rst), .ce(ce), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
        .link(link), .global_order(global_order), .pause_off_act(pause_off_act),
        .pause_inval_req(pause_inval_req), .egress_queue_mode(egress_queue_mode),
        .core_regulator_dis(core_regulator_dis),
        .port_default_vlan_id_ins(port_default_vlan_id_ins), .irq_out_low(irq_out_low)
    );

    sacir_host sacir_host_inst (
        .clk(clk), .req(req), .rd_data(rd_data), .rd_valid(rd_valid)
    );

    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        sacir_host_inst.read_reg(a, rv, vv);
        check("rd_valid", {7'h00, vv}, 8'h01);
        check($sformatf("register %h", a), rv, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sacir_host_inst.write_reg(a, d);
    endtask

    // A link change lands in the flag at the first edge after it; the task waits two cycles
    task automatic flip(input int b);
        @(negedge clk);
        link[b] = ~link[b];
        repeat (2) @(negedge clk);
    endtask

    task automatic summarize;
        if (miscompares == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst, ce, global_order, pause_off_act} = 4'b1100;
        link = '0;
        {miscompares, tests_run, cycles} = '0;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd_chk(offs[i], rsts[i]);
        end
        check("mode", 8'(egress_queue_mode), 8'h01);
        check("irq_out_low", {7'h00, irq_out_low}, 8'h01);
        // Writable and read-only fields
        wr(`SACIR_OFF_SCHED, 8'h00);
        rd_chk(`SACIR_OFF_SCHED, 8'h01);
        check("mode", 8'(egress_queue_mode), 8'h00);
        // Global order bit alone overrides strict service
        global_order = 1'b1;
        @(negedge clk);
        check("mode", 8'(egress_queue_mode), 8'h01);
        global_order = 1'b0;
        wr(`SACIR_OFF_SCHED, 8'hff);
        rd_chk(`SACIR_OFF_SCHED, 8'h81);
        check("mode", 8'(egress_queue_mode), 8'h01);
        wr(`SACIR_OFF_RSVD_C0, 8'h00);
        rd_chk(`SACIR_OFF_RSVD_C0, 8'h03);
        wr(`SACIR_OFF_REGUL, 8'hff);
        rd_chk(`SACIR_OFF_REGUL, 8'h40);
        check("regulator", {7'h00, core_regulator_dis}, 8'h01);
        wr(`SACIR_OFF_REGUL, 8'h00);
        check("regulator", {7'h00, core_regulator_dis}, 8'h00);
        wr(`SACIR_OFF_PAUSE, 8'ha5);
        rd_chk(`SACIR_OFF_PAUSE, 8'ha5);
        for (int i = 0; i < 6; i++) begin
            wr(`SACIR_OFF_VLAN_INS, 8'hc0 | (8'h01 << i));
            rd_chk(`SACIR_OFF_VLAN_INS, 8'h01 << i);
            check("vlan", {2'b00, port_default_vlan_id_ins}, 8'h01 << i);
        end
        // A write while the clock enable is low is lost
        ce = 1'b0;
        wr(`SACIR_OFF_REGUL, 8'h40);
        ce = 1'b1;
        rd_chk(`SACIR_OFF_REGUL, 8'h00);
        // Link change flags and the interrupt pin
        sacir_host_inst.arm_irq(8'h87);
        flip(0);
        check("irq_out_low", {7'h00, irq_out_low}, 8'h00);
        rd_chk(`SACIR_OFF_IRQ_STAT, 8'h81);
        wr(`SACIR_OFF_IRQ_STAT, 8'h00);
        rd_chk(`SACIR_OFF_IRQ_STAT, 8'h81);
        wr(`SACIR_OFF_IRQ_STAT, 8'h01);
        rd_chk(`SACIR_OFF_IRQ_STAT, 8'h80);
        check("irq_out_low", {7'h00, irq_out_low}, 8'h00);
        wr(`SACIR_OFF_IRQ_STAT, 8'h80);
        check("irq_out_low", {7'h00, irq_out_low}, 8'h01);
        // A clear and a new event in one cycle: the event wins
        fork
            sacir_host_inst.write_reg(`SACIR_OFF_IRQ_STAT, 8'h81);
            begin
                @(negedge clk);
                link[0] = ~link[0];
            end
        join
        rd_chk(`SACIR_OFF_IRQ_STAT, 8'h81);
        wr(`SACIR_OFF_IRQ_STAT, 8'hff);
        flip(1);
        rd_chk(`SACIR_OFF_IRQ_STAT, 8'h82);
        wr(`SACIR_OFF_IRQ_STAT, 8'hff);
        flip(2);
        rd_chk(`SACIR_OFF_IRQ_STAT, 8'h04);
        wr(`SACIR_OFF_IRQ_STAT, 8'h7c);
        rd_chk(`SACIR_OFF_IRQ_STAT, 8'h00);
        sacir_host_inst.arm_irq(8'h00);
        flip(2);
        rd_chk(`SACIR_OFF_IRQ_STAT, 8'h04);
        check("irq_out_low", {7'h00, irq_out_low}, 8'h01);
        // Pause-off limit: exact delay, release, and no request while disabled
        wr(`SACIR_OFF_PAUSE, 8'h01);
        pause_off_act = 1'b1;
        n = 0;
        while (pause_inval_req !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check("pause delay", n[7:0], 8'(LIMIT));
        pause_off_act = 1'b0;
        @(negedge clk);
        check("pause request", {7'h00, pause_inval_req}, 8'h00);
        wr(`SACIR_OFF_PAUSE, 8'h00);
        pause_off_act = 1'b1;
        repeat (2 * LIMIT) @(negedge clk);
        check("pause request", {7'h00, pause_inval_req}, 8'h00);
        pause_off_act = 1'b0;
        summarize();
    end
endmodule // testbench
